// File: src/prs_defines.svh
// Constants for the reference switchover and phase detector control block.
// Assumes a 32-bit AHB-Lite slave, one word per register index.
`ifndef PRS_DEFINES_SVH
`define PRS_DEFINES_SVH

// ----------------------------------------------------------------------
// Register indices and address bit range
// ----------------------------------------------------------------------
`define PRS_IDX_PLL_CTL 8'h10
`define PRS_IDX_ABP 8'h17
`define PRS_IDX_VCO_CAL 8'h18
`define PRS_IDX_REF_CTL 8'h1C
`define PRS_IDX_STATUS 8'h1F
`define PRS_IDX_PUMP_CUR 8'h20
`define PRS_ADDR_LSB 2
`define PRS_ADDR_MSB 9

// ----------------------------------------------------------------------
// Pll control fields
// ----------------------------------------------------------------------
`define PRS_PD_LSB 0
`define PRS_PD_MSB 1
`define PRS_EXT_OSC_BIT 3
`define PRS_MODE_LSB 4
`define PRS_MODE_MSB 6
`define PRS_POL_BIT 7

// ----------------------------------------------------------------------
// Reference control fields
// ----------------------------------------------------------------------
`define PRS_DIFF_BIT 0
`define PRS_PRI_PD_BIT 1
`define PRS_SEC_PD_BIT 2
`define PRS_STAY_BIT 3
`define PRS_AUTO_BIT 4
`define PRS_MAN_SEL_BIT 5
`define PRS_PIN_SEL_BIT 6
`define PRS_DGL_OFF_BIT 7

// ----------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------
`define PRS_RST_PLL_CTL 8'h00
`define PRS_RST_REF_CTL 8'h06
`define PRS_RST_ABP 2'h0
`define PRS_RST_CUR 3'h0
`define PRS_MISS_FALLS 2'h2
`define PRS_BACK_RISES 3'h4

`endif

// File: src/prs_pkg.sv
// Types for the reference switchover and phase detector control block.
// Assumes prs_defines.svh is available on the include path.
package prs_pkg;

    // ------------------------------------------------------------------
    // Reference selection states, Gray coded around the loop
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PRS_ON_PRI = 2'b00,
        PRS_TO_SEC = 2'b01,
        PRS_ON_SEC = 2'b11,
        PRS_TO_PRI = 2'b10
    } prs_sel_t;

    // ------------------------------------------------------------------
    // Charge pump modes
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        PRS_CP_HIZ = 3'h0,
        PRS_CP_NORMAL = 3'h1,
        PRS_CP_UP = 3'h2,
        PRS_CP_DOWN = 3'h3
    } prs_cp_t;

endpackage

// File: src/prs_top.sv
// Reference input control, switchover, phase detector and pump control.
// Assumes reference and divider inputs well below half the 40 MHz clock.
//
// How it works
// - Antibacklash width from two-bit register field
// - Pump mode: high-Z, normal, forced up, down
// - Eight-step pump current code driven out
// - Reference control selects differential or single-ended
// - All reference buffers off after reset
// - Differential buffer off unless selected and powered
// - Single-ended buffer off on power-down or own bit
// - Differential mode forces single-ended buffers off
// - Switching only in single-ended mode
// - Manual mode follows register bit or pin
// - Prefer-primary mode returns when primary back
// - Stay mode keeps secondary after primary returns
// - Missing after two secondary falls, no primary edge
// - Hand over on next secondary rising edge
// - Revert after four primary rises, no missing
// - Manual switch waits for target edge unless deglitch off
// - Deglitch aligns change with new reference edge
// - Phase detector compares dividers, drives up/down
// - Polarity applies only with external oscillator
// - Polarity clear positive, set negative sense
`timescale 1ns/1ps
`default_nettype none
`include "prs_defines.svh"

module prs_top (
    input wire logic clock,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic primary_reference,
    input wire logic secondary_reference,
    input wire logic ref_select_pin,
    input wire logic ref_div_out,
    input wire logic fb_div_out,
    output logic diff_buf_en,
    output logic pri_buf_en,
    output logic sec_buf_en,
    output logic ref_mux_sel,
    output logic pump_up,
    output logic pump_down,
    output logic pump_hiz,
    output logic [2:0] pump_current,
    output logic [1:0] antibacklash,
    output logic vco_cal
);
    import prs_pkg::*;

    // ------------------------------------------------------------------
    // Edge helpers and input synchronisers
    // ------------------------------------------------------------------
    // Rising edge between a synchronised level and its delayed copy
    function automatic logic rise(input logic cur, input logic prev);
        rise = cur & ~prev;
    endfunction
    // Falling edge between a synchronised level and its delayed copy
    function automatic logic fall(input logic cur, input logic prev);
        fall = ~cur & prev;
    endfunction

    logic [4:0] s1_q, s1_d; // First stage, read only by second stage
    logic [4:0] s2_q, s2_d; // Second stage, usable levels
    logic [4:0] s3_q, s3_d; // Delayed copy for edge detection

    // Next values of the synchroniser chain
    always_comb begin
        s1_d = {fb_div_out, ref_div_out, ref_select_pin,
                secondary_reference, primary_reference};
        s2_d = s1_q;
        s3_d = s2_q;
    end

    // Registers of the synchroniser chain
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s1_q <= 5'h00;
            s2_q <= 5'h00;
            s3_q <= 5'h00;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            s3_q <= s3_d;
        end
    end

    wire logic pri_rise = rise(s2_q[0], s3_q[0]); // Primary rise
    wire logic pri_edge = pri_rise | fall(s2_q[0], s3_q[0]); // Either edge
    wire logic sec_rise = rise(s2_q[1], s3_q[1]); // Secondary rise
    wire logic sec_fall = fall(s2_q[1], s3_q[1]); // Secondary fall
    wire logic pin_sel = s2_q[2]; // Synchronised select pin
    wire logic rdiv_rise = rise(s2_q[3], s3_q[3]); // Reference divider rise
    wire logic fdiv_rise = rise(s2_q[4], s3_q[4]); // Feedback divider rise

    // ------------------------------------------------------------------
    // Register file and AHB-Lite slave
    // ------------------------------------------------------------------
    logic [7:0] ctl_q, ctl_d; // Pll control
    logic [7:0] ref_q, ref_d; // Reference control
    logic [1:0] abp_q, abp_d; // Antibacklash setting
    logic cal_q, cal_d; // Oscillator calibration start
    logic [2:0] cur_q, cur_d; // Pump current code
    logic wr_q, wr_d; // Write data phase pending
    logic [7:0] widx_q, widx_d; // Index of pending write
    logic [31:0] rdat_q, rdat_d; // Read data for the data phase
    logic missing_q; // Primary declared missing
    prs_sel_t sel_q; // Selection state
    wire logic [7:0] aidx = haddr[`PRS_ADDR_MSB:`PRS_ADDR_LSB]; // Index
    wire logic acc = hsel & htrans[1] & hready; // Valid address phase

    // Write in the data phase, read data from the next register values
    always_comb begin
        ctl_d = ctl_q;
        ref_d = ref_q;
        abp_d = abp_q;
        cal_d = cal_q;
        cur_d = cur_q;
        rdat_d = 32'h0000_0000;
        if (wr_q) begin
            unique case (widx_q)
                `PRS_IDX_PLL_CTL: ctl_d = hwdata[7:0];
                `PRS_IDX_REF_CTL: ref_d = hwdata[7:0];
                `PRS_IDX_ABP: abp_d = hwdata[1:0];
                `PRS_IDX_VCO_CAL: cal_d = hwdata[0];
                `PRS_IDX_PUMP_CUR: cur_d = hwdata[2:0];
                default: ; // Unmapped or read-only: ignored
            endcase
        end
        wr_d = acc & hwrite;
        widx_d = aidx;
        if (acc & ~hwrite) begin
            unique case (aidx)
                `PRS_IDX_PLL_CTL: rdat_d = {24'h000000, ctl_d};
                `PRS_IDX_REF_CTL: rdat_d = {24'h000000, ref_d};
                `PRS_IDX_ABP: rdat_d = {30'h00000000, abp_d};
                `PRS_IDX_VCO_CAL: rdat_d = {31'h00000000, cal_d};
                `PRS_IDX_PUMP_CUR: rdat_d = {29'h00000000, cur_d};
                `PRS_IDX_STATUS: rdat_d = {26'h0000000, sec_buf_en,
                    pri_buf_en, diff_buf_en, sel_q != PRS_ON_PRI &&
                    sel_q != PRS_ON_SEC, missing_q, sel_q[1]};
                default: rdat_d = 32'h0000_0000; // Unmapped reads zero
            endcase
        end
    end

    // Registers of the bus slave and register file
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ctl_q <= `PRS_RST_PLL_CTL;
            ref_q <= `PRS_RST_REF_CTL;
            abp_q <= `PRS_RST_ABP;
            cal_q <= 1'b0;
            cur_q <= `PRS_RST_CUR;
            wr_q <= 1'b0;
            widx_q <= 8'h00;
            rdat_q <= 32'h0000_0000;
        end else begin
            ctl_q <= ctl_d;
            ref_q <= ref_d;
            abp_q <= abp_d;
            cal_q <= cal_d;
            cur_q <= cur_d;
            wr_q <= wr_d;
            widx_q <= widx_d;
            rdat_q <= rdat_d;
        end
    end

    assign hrdata = rdat_q;
    assign hreadyout = 1'b1; // Zero wait states, constant
    assign hresp = 1'b0; // Always OKAY
    // Decoded controls; manual target 1 selects secondary
    wire logic pll_pd = ctl_q[`PRS_PD_MSB:`PRS_PD_LSB] != 2'h0; // Pll off
    wire logic diff_mode = ref_q[`PRS_DIFF_BIT];
    wire logic auto_on = ref_q[`PRS_AUTO_BIT] & ~diff_mode;
    wire logic manual_tgt = ref_q[`PRS_PIN_SEL_BIT] ? pin_sel :
                            ref_q[`PRS_MAN_SEL_BIT];

    // ------------------------------------------------------------------
    // Primary monitor and reference selection
    // ------------------------------------------------------------------
    logic [1:0] falls_q, falls_d; // Secondary falls since primary edge
    logic [2:0] rises_q, rises_d; // Primary rises since declared missing
    logic missing_d;

    // Count secondary falls against primary activity
    always_comb begin
        falls_d = auto_on ? falls_q : 2'h0; // Watch idle outside auto
        rises_d = auto_on ? rises_q : 3'h0;
        missing_d = auto_on & missing_q;
        if (auto_on && pri_edge) begin
            falls_d = 2'h0; // Primary alive, restart watch
            if (pri_rise && missing_q) begin
                rises_d = rises_q + 3'h1;
                if (rises_d == `PRS_BACK_RISES) begin
                    missing_d = 1'b0;
                    rises_d = 3'h0;
                end
            end
        end else if (auto_on && sec_fall) begin
            if (falls_q + 2'h1 == `PRS_MISS_FALLS) begin
                missing_d = 1'b1;
                rises_d = 3'h0; // Two falls break the return count
                falls_d = 2'h0;
            end else begin
                falls_d = falls_q + 2'h1;
            end
        end
    end

    // Registers of the primary monitor
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            falls_q <= 2'h0;
            rises_q <= 3'h0;
            missing_q <= 1'b0;
        end else begin
            falls_q <= falls_d;
            rises_q <= rises_d;
            missing_q <= missing_d;
        end
    end

    prs_sel_t sel_d;
    wire logic want_sec = diff_mode ? 1'b0 :
                          auto_on ? missing_q : manual_tgt;
    wire logic want_pri = diff_mode ? 1'b1 :
                          auto_on ? (~missing_q & ~ref_q[`PRS_STAY_BIT]) :
                          ~manual_tgt;
    wire logic now_ok = ~auto_on & ref_q[`PRS_DGL_OFF_BIT];

    // Move to the new reference at its rising edge, or at once in manual mode with deglitch off
    always_comb begin
        sel_d = sel_q;
        unique case (sel_q)
            PRS_ON_PRI: if (want_sec) sel_d = now_ok ? PRS_ON_SEC : PRS_TO_SEC;
            PRS_TO_SEC: begin
                if (!want_sec) sel_d = PRS_ON_PRI; // Request withdrawn
                else if (sec_rise || now_ok) sel_d = PRS_ON_SEC;
            end
            PRS_ON_SEC: if (want_pri) sel_d = now_ok ? PRS_ON_PRI : PRS_TO_PRI;
            PRS_TO_PRI: begin
                if (!want_pri) sel_d = PRS_ON_SEC; // Request withdrawn
                else if (pri_rise || now_ok) sel_d = PRS_ON_PRI;
            end
        endcase
    end

    // Register of the selection state
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sel_q <= PRS_ON_PRI;
        end else begin
            sel_q <= sel_d;
        end
    end

    // ------------------------------------------------------------------
    // Phase detector and output stage
    // ------------------------------------------------------------------
    logic pd_up_q, pd_up_d; // Reference leads
    logic pd_dn_q, pd_dn_d; // Feedback leads
    logic [1:0] abc_q, abc_d; // Antibacklash overlap counter

    // Set on divider edges, clear both after the overlap time
    always_comb begin
        pd_up_d = pd_up_q | rdiv_rise;
        pd_dn_d = pd_dn_q | fdiv_rise;
        abc_d = 2'h0;
        if (pd_up_q && pd_dn_q) begin
            if (abc_q == abp_q) begin
                pd_up_d = rdiv_rise;
                pd_dn_d = fdiv_rise;
            end else begin
                abc_d = abc_q + 2'h1;
            end
        end
    end

    // Registers of the phase detector
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pd_up_q <= 1'b0;
            pd_dn_q <= 1'b0;
            abc_q <= 2'h0;
        end else begin
            pd_up_q <= pd_up_d;
            pd_dn_q <= pd_dn_d;
            abc_q <= abc_d;
        end
    end

    logic diff_en_q, diff_en_d; // Differential buffer power
    logic pri_en_q, pri_en_d; // Primary buffer power
    logic sec_en_q, sec_en_d; // Secondary buffer power
    logic up_q, up_d; // Pump up drive
    logic dn_q, dn_d; // Pump down drive
    logic hiz_q, hiz_d; // Pump high impedance
    logic swap; // Negative sense with external oscillator

    // Buffer power and pump drive
    always_comb begin
        diff_en_d = ~pll_pd & diff_mode;
        pri_en_d = ~pll_pd & ~diff_mode & ~ref_q[`PRS_PRI_PD_BIT];
        sec_en_d = ~pll_pd & ~diff_mode & ~ref_q[`PRS_SEC_PD_BIT];
        swap = ctl_q[`PRS_EXT_OSC_BIT] & ctl_q[`PRS_POL_BIT];
        up_d = 1'b0;
        dn_d = 1'b0;
        hiz_d = 1'b0;
        unique case (ctl_q[`PRS_MODE_MSB:`PRS_MODE_LSB])
            PRS_CP_NORMAL: begin
                up_d = swap ? pd_dn_q : pd_up_q;
                dn_d = swap ? pd_up_q : pd_dn_q;
            end
            PRS_CP_UP: up_d = 1'b1;
            PRS_CP_DOWN: dn_d = 1'b1;
            default: hiz_d = 1'b1;
        endcase
    end

    // Registers of the output stage
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            diff_en_q <= 1'b0;
            pri_en_q <= 1'b0;
            sec_en_q <= 1'b0;
            up_q <= 1'b0;
            dn_q <= 1'b0;
            hiz_q <= 1'b1;
        end else begin
            diff_en_q <= diff_en_d;
            pri_en_q <= pri_en_d;
            sec_en_q <= sec_en_d;
            up_q <= up_d;
            dn_q <= dn_d;
            hiz_q <= hiz_d;
        end
    end

    assign diff_buf_en = diff_en_q;
    assign pri_buf_en = pri_en_q;
    assign sec_buf_en = sec_en_q;
    assign ref_mux_sel = sel_q[1];
    assign pump_up = up_q;
    assign pump_down = dn_q;
    assign pump_hiz = hiz_q;
    assign pump_current = cur_q;
    assign antibacklash = abp_q;
    assign vco_cal = cal_q;

endmodule // prs_top
`default_nettype wire

// File: verif/prs_assertions.sv
// Checker for the reference switchover and pump control block.
// Assumes it sees only the top-level ports of prs_top, bound from the bench.
`timescale 1ns/1ps
`default_nettype none

module prs_chk (
    input wire logic clock,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic diff_buf_en,
    input wire logic pri_buf_en,
    input wire logic sec_buf_en,
    input wire logic pump_up,
    input wire logic pump_down,
    input wire logic pump_hiz,
    input wire logic [2:0] pump_current,
    input wire logic [1:0] antibacklash
);
    // ------------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------------
    logic wr_now; // Write taken at this edge
    logic rd_now; // Read taken at this edge
    logic [3:0] wr_q; // Recent write history
    logic [3:0] wr_d; // Next write history
    assign wr_now = hsel && htrans[1] && hwrite && hready;
    assign rd_now = hsel && htrans[1] && !hwrite && hready;
    // Shift in each taken write
    always_comb begin
        wr_d = {wr_q[2:0], wr_now};
    end
    // Register the history
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wr_q <= 4'h0;
        end else begin
            wr_q <= wr_d;
        end
    end
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    AST_BUS_OKAY: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    AST_RDATA_IDLE: assert property (!$past(rd_now) |-> hrdata == 32'h0)
        else $error("read data not cleared outside data phase");
    AST_DIFF_EXCL: assert property (
        diff_buf_en |-> !pri_buf_en && !sec_buf_en)
        else $error("single-ended buffer on in differential mode");
    AST_HIZ_QUIET: assert property (
        pump_hiz && $past(pump_hiz) |-> !pump_up && !pump_down)
        else $error("pump command while high impedance");
    AST_ABL_CLEAR: assert property (
        pump_up && pump_down |-> ##[1:6] !(pump_up && pump_down))
        else $error("pump up and down not cleared together");
    AST_ABL_CFG: assert property (
        $changed(antibacklash) |-> wr_q != 4'h0)
        else $error("antibacklash changed without a write");
    AST_CUR_CFG: assert property (
        $changed(pump_current) |-> wr_q != 4'h0)
        else $error("pump current changed without a write");
    AST_BUF_CAUSE: assert property (
        $rose(diff_buf_en) || $rose(pri_buf_en) || $rose(sec_buf_en)
        |-> wr_q != 4'h0)
        else $error("reference buffer powered without a write");

    COV_BOTH: cover property (pump_up && pump_down);
    COV_DIFF: cover property ($rose(diff_buf_en));
    COV_ABL: cover property ($changed(antibacklash));
endmodule // prs_chk
`default_nettype wire

// File: verif/prs_ref_src.sv
// Model of the two single-ended reference sources beside the block.
// Assumes 1 ns time unit; a stopped source is driven CMOS holding level.
`timescale 1ns/1ps
`default_nettype none

module prs_ref_src #(
    parameter int PRI_HALF = 200,
    parameter int SEC_HALF = 250
) (
    input wire logic pri_run,
    input wire logic sec_run,
    output logic pri_ref,
    output logic sec_ref
);
    // Primary source, toggles only while running
    initial begin
        pri_ref = 1'b0;
        forever begin
            #(PRI_HALF);
            if (pri_run) pri_ref = ~pri_ref;
        end
    end
    // Secondary source, slower than the primary
    initial begin
        sec_ref = 1'b0;
        forever begin
            #(SEC_HALF);
            if (sec_run) sec_ref = ~sec_ref;
        end
    end
endmodule // prs_ref_src
`default_nettype wire

// File: verif/tb_pll_reference_switchover.sv
// Self-checking bench for reference switchover and pump control.
// Assumes prs_top, prs_chk and prs_ref_src are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "prs_defines.svh"

module tb_pll_reference_switchover;
    localparam logic [7:0] REF = `PRS_IDX_REF_CTL;
    localparam logic [7:0] PLL = `PRS_IDX_PLL_CTL;
    localparam logic [7:0] STS = `PRS_IDX_STATUS;
    logic clock, rst, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans, antibacklash;
    logic [2:0] hsize, pump_current;
    logic primary_reference, secondary_reference, ref_select_pin;
    logic ref_div_out, fb_div_out, pri_run, sec_run;
    logic diff_buf_en, pri_buf_en, sec_buf_en, ref_mux_sel;
    logic pump_up, pump_down, pump_hiz, vco_cal;
    int err_count, tests_run;
    // Pump mode table: control value and expected hiz, up, down
    logic [7:0] pc [8] = '{8'h10, 8'h90, 8'h98, 8'h18,
                           8'h20, 8'h30, 8'h00, 8'h70};
    logic [2:0] pe [8] = '{3'h2, 3'h2, 3'h1, 3'h2, 3'h2, 3'h1, 3'h4, 3'h4};
    // Buffer table: pll control, reference control, diff/pri/sec
    logic [7:0] bp [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01};
    logic [7:0] br [6] = '{8'h00, 8'h04, 8'h02, 8'h01, 8'h01, 8'h00};
    logic [2:0] be [6] = '{3'h3, 3'h2, 3'h1, 3'h4, 3'h0, 3'h0};

    assign hready = hreadyout;
    prs_top dut_u (.clock, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready, .hrdata, .hreadyout, .hresp, .primary_reference,
        .secondary_reference, .ref_select_pin, .ref_div_out, .fb_div_out,
        .diff_buf_en, .pri_buf_en, .sec_buf_en, .ref_mux_sel, .pump_up,
        .pump_down, .pump_hiz, .pump_current, .antibacklash, .vco_cal);
    prs_ref_src src_u (.pri_run, .sec_run, .pri_ref(primary_reference),
        .sec_ref(secondary_reference));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask
    // One single AHB-Lite transfer, waits on hready in both phases
    task automatic bus(input logic w, input logic [7:0] idx,
                       input logic [31:0] wd, output logic [31:0] rd);
        logic rdy;
        @(posedge clock);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {22'h000000, idx, 2'b00};
        do begin
            @(negedge clock);
            rdy = hreadyout;
            @(posedge clock);
        end while (rdy !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do begin
            @(negedge clock);
            rdy = hreadyout;
            rd = hrdata;
            @(posedge clock);
        end while (rdy !== 1'b1);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, idx, d, x);
    endtask
    task automatic rdc(input logic [7:0] idx, input logic [31:0] m,
                       input logic [31:0] exp);
        logic [31:0] x;
        bus(1'b0, idx, 32'h0, x);
        chk(x & m, exp);
    endtask
    // Wait a bounded time for the select line to reach a level
    task automatic mux_wait(input logic v, input int n);
        int i;
        for (i = 0; i < n && ref_mux_sel !== v; i++) @(negedge clock);
        chk({31'h0, ref_mux_sel}, {31'h0, v});
    endtask
    task automatic mux_hold(input logic v, input int n);
        cyc(n);
        chk({31'h0, ref_mux_sel}, {31'h0, v});
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        chk({29'h0, diff_buf_en, pri_buf_en, sec_buf_en}, 32'h0);
        chk({31'h0, pump_hiz}, 32'h1);
        rdc(REF, 32'hFF, `PRS_RST_REF_CTL);
        rdc(8'h30, 32'hFFFFFFFF, 32'h0);
    endtask
    task automatic t_regs();
        for (int i = 0; i < 8; i++) begin
            wr(`PRS_IDX_ABP, i % 4);
            wr(`PRS_IDX_PUMP_CUR, i);
            cyc(4);
            chk({30'h0, antibacklash}, i % 4);
            chk({29'h0, pump_current}, i);
            rdc(`PRS_IDX_PUMP_CUR, 32'h7, i);
        end
        wr(`PRS_IDX_VCO_CAL, 32'h1);
        cyc(4);
        chk({31'h0, vco_cal}, 32'h1);
        wr(`PRS_IDX_VCO_CAL, 32'h0);
    endtask
    task automatic t_bufs();
        for (int i = 0; i < 6; i++) begin
            wr(PLL, bp[i]);
            wr(REF, br[i]);
            cyc(4);
            chk({29'h0, diff_buf_en, pri_buf_en, sec_buf_en}, be[i]);
        end
        wr(PLL, 32'h0);
    endtask
    task automatic t_pump();
        for (int i = 0; i < 8; i++) begin
            wr(PLL, pc[i]);
            cyc(4);
            @(posedge clock);
            ref_div_out <= 1'b1;
            cyc(8);
            chk({29'h0, pump_hiz, pump_up, pump_down}, pe[i]);
            @(posedge clock);
            fb_div_out <= 1'b1;
            cyc(12);
            if (i < 4) chk({29'h0, pump_hiz, pump_up, pump_down}, 0);
            @(posedge clock);
            ref_div_out <= 1'b0;
            fb_div_out <= 1'b0;
            cyc(8);
        end
        wr(PLL, 32'h0);
    endtask
    task automatic t_manual();
        wr(REF, 32'h20);
        mux_wait(1'b1, 60);
        wr(REF, 32'h00);
        mux_wait(1'b0, 60);
        wr(REF, 32'h40);
        @(posedge clock);
        ref_select_pin <= 1'b1;
        mux_wait(1'b1, 60);
        @(posedge clock);
        ref_select_pin <= 1'b0;
        mux_wait(1'b0, 60);
        @(posedge clock);
        sec_run <= 1'b0;
        wr(REF, 32'h20);
        mux_hold(1'b0, 60);
        wr(REF, 32'hA0);
        mux_wait(1'b1, 8);
        @(posedge clock);
        sec_run <= 1'b1;
        wr(REF, 32'h00);
        mux_wait(1'b0, 60);
        wr(REF, 32'h21);
        mux_hold(1'b0, 60);
        wr(REF, 32'h00);
    endtask
    task automatic t_auto();
        wr(REF, 32'h10);
        cyc(60);
        rdc(STS, 32'h3, 32'h0);
        @(posedge clock);
        pri_run <= 1'b0;
        mux_hold(1'b0, 12);
        mux_wait(1'b1, 120);
        rdc(STS, 32'h3, 32'h3);
        @(posedge clock);
        pri_run <= 1'b1;
        mux_hold(1'b1, 40);
        mux_wait(1'b0, 150);
        rdc(STS, 32'h3, 32'h0);
    endtask
    task automatic t_stay();
        wr(REF, 32'h18);
        @(posedge clock);
        pri_run <= 1'b0;
        mux_wait(1'b1, 120);
        @(posedge clock);
        pri_run <= 1'b1;
        mux_hold(1'b1, 150);
        wr(REF, 32'h08);
        mux_wait(1'b0, 60);
        wr(REF, 32'h18);
        mux_hold(1'b0, 100);
    endtask

    // ------------------------------------------------------------------
    // Clock, sequence, watchdog and verdict
    // ------------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        #500000;
        err_count++;
        finish_test();
    end
    initial begin
        rst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        ref_select_pin = 1'b0;
        ref_div_out = 1'b0;
        fb_div_out = 1'b0;
        pri_run = 1'b1;
        sec_run = 1'b1;
        err_count = 0;
        tests_run = 0;
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        t_reset();
        t_regs();
        t_bufs();
        t_pump();
        t_manual();
        t_auto();
        t_stay();
        finish_test();
    end
endmodule // tb_pll_reference_switchover

bind prs_top prs_chk chk_u (.clock, .rst, .hsel, .htrans, .hwrite, .hready,
    .hrdata, .hreadyout, .hresp, .diff_buf_en, .pri_buf_en, .sec_buf_en,
    .pump_up, .pump_down, .pump_hiz, .pump_current, .antibacklash);
`default_nettype wire
